// ### include/tmsl_pkg.sv
// Package for the torque-mode speed limiter: register map, field codes, reset values.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package tmsl_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL      = 8'h00;   // Mode, source, input levels
    localparam logic [7:0] REG_FILT      = 8'h04;   // Filter time constant shift
    localparam logic [7:0] REG_LIMIT     = 8'h08;   // Stored limit value, signed
    localparam logic [7:0] REG_BIAS      = 8'h0C;   // Bias, percent of max freq
    localparam logic [7:0] REG_COMM      = 8'h10;   // Limit written over serial link
    localparam logic [7:0] REG_MAXF      = 8'h14;   // Max output frequency, speed units
    localparam logic [7:0] REG_STAT      = 8'h18;   // Window state, torque mode
    localparam logic [7:0] REG_UPPER     = 8'h1C;   // Upper boundary readback
    localparam logic [7:0] REG_LOWER     = 8'h20;   // Lower boundary readback
    localparam logic [7:0] REG_TORQUE    = 8'h24;   // Torque output readback
    // Control field positions
    localparam int CTRL_MODE_BIT   = 0;             // Control mode select
    localparam int CTRL_SRC_LSB    = 4;             // Limit source select, 2 bits
    localparam int CTRL_AIN1_LSB   = 8;             // Input level select of first input
    localparam int CTRL_FN2_LSB    = 12;            // Function code of second input
    localparam int CTRL_FSRC_LSB   = 20;            // Frequency source select
    // Field codes
    localparam logic [1:0] SRC_ANALOG  = 2'h0;
    localparam logic [1:0] SRC_STORED  = 2'h1;
    localparam logic [1:0] SRC_COMM    = 2'h2;
    localparam logic [7:0] FN2_ADD     = 8'h0C;     // Second input adds to first
    localparam logic [3:0] FSRC_ANALOG = 4'h1;      // Analog reference frequency
    localparam logic [7:0] DI_FN_TORQ  = 8'h2C;     // Digital input mode switch code
    // Reset values
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [3:0]  FILT_RST   = 4'h4;
    localparam logic [15:0] MAXF_RST   = 16'h2710;
    // Window state codes
    typedef enum logic [1:0] {
        WIN_INSIDE = 2'b00,
        WIN_ABOVE  = 2'b01,
        WIN_BELOW  = 2'b10
    } tmsl_win_e;
endpackage

// ### sim/tb_tmsl_top.sv
// Bench for tmsl_top: registers, limit sources, window override, filter.
// Motor model supplies speed; checker bound below the module.
module tb_tmsl_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic signed [15:0] PULL = 16'h0400;
    logic               clk_sys = 1'b0, rst_b = 1'b0;
    logic               wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]         wb_adr_i = 8'h00;
    logic [3:0]         wb_sel_i = 4'hF;
    logic [31:0]        wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic               wb_ack_o, torque_mode;
    logic signed [15:0] analog_input_one = 16'hFED4, analog_input_two = 16'h0064;
    logic signed [15:0] torque_ref = 16'h0, spd = 16'h0, speed_fb, torque_pull, torque_out;
    logic [7:0]         dig_in = 8'h00;
    logic [63:0]        dig_fn = 64'h0;
    int                 num_errors = 0, checks = 0, cycles = 0;

    always #2 clk_sys = ~clk_sys;

    tmsl_top i_tmsl_top (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .analog_input_one, .analog_input_two,
        .dig_in, .dig_fn, .speed_fb, .torque_ref, .torque_pull, .torque_out, .torque_mode);
    tmsl_motor_model i_tmsl_motor_model (.clk_sys, .rst_b, .speed_set(spd), .torque_out,
        .speed_fb, .torque_pull);

    // Cut a hang short
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One classic cycle; read data lands in rdat
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb(a, 1'b0, 32'h0);
        chk(rdat, exp);
    endtask

    // Set speed, then judge torque and status
    task automatic t_spd(input int s, input logic signed [15:0] et, input logic [2:0] es);
        spd <= 16'(s);
        repeat (4) @(posedge clk_sys);
        chk(32'(torque_out), 32'(et));
        rd_chk(tmsl_pkg::REG_STAT, {29'h0, es});
    endtask

    task automatic t_reset();
        rd_chk(tmsl_pkg::REG_CTRL, tmsl_pkg::CTRL_RST);
        rd_chk(tmsl_pkg::REG_FILT, {28'h0, tmsl_pkg::FILT_RST});
        rd_chk(tmsl_pkg::REG_MAXF, {16'h0, tmsl_pkg::MAXF_RST});
        wb_sel_i <= 4'h1;
        wb(tmsl_pkg::REG_MAXF, 1'b1, 32'h0000_1234);
        wb_sel_i <= 4'hF;
        rd_chk(tmsl_pkg::REG_MAXF, {16'h0, tmsl_pkg::MAXF_RST});
        wb(8'h40, 1'b1, 32'hFFFF_FFFF);
        rd_chk(8'h40, 32'h0);
    endtask

    // Program source, limit, bias; check bounds, the zones beyond bounds not at the range ends, and inside when bounds are over 1 apart
    task automatic t_win(input logic [31:0] ctrl, input int lim, bias, comm, up, lo);
        wb(tmsl_pkg::REG_CTRL, 1'b1, ctrl);
        wb(tmsl_pkg::REG_LIMIT, 1'b1, 32'(lim));
        wb(tmsl_pkg::REG_BIAS, 1'b1, 32'(bias));
        wb(tmsl_pkg::REG_COMM, 1'b1, 32'(comm));
        repeat (4) @(posedge clk_sys);
        rd_chk(tmsl_pkg::REG_UPPER, 32'(up));
        rd_chk(tmsl_pkg::REG_LOWER, 32'(lo));
        if (up < 32767)
            t_spd(up + 1, -PULL, 3'h5);
        if (lo > -32768)
            t_spd(lo - 1, PULL, 3'h6);
        if (up - lo > 1)
            t_spd((up + lo) / 2, 16'h0, 3'h4);
    endtask

    task automatic t_speed();
        wb(tmsl_pkg::REG_CTRL, 1'b1, 32'h10);
        wb(tmsl_pkg::REG_LIMIT, 1'b1, 32'h0);
        t_spd(20000, 16'h0, 3'h0);
        dig_fn[7:0] <= 8'h2B;
        dig_in[0] <= 1'b1;
        t_spd(20000, 16'h0, 3'h0);
        dig_fn[7:0] <= tmsl_pkg::DI_FN_TORQ;
        t_spd(20000, -PULL, 3'h5);
        dig_in[0] <= 1'b0;
    endtask

    task automatic t_filt();
        int acc;
        acc = 0;
        repeat (400) acc += (32'sh1000_0000 - acc) >>> 4;
        torque_ref <= 16'h1000;
        repeat (400) @(posedge clk_sys);
        chk(32'(torque_out), {16'h0, acc[31:16]});
        wb(tmsl_pkg::REG_FILT, 1'b1, 32'h0);
        repeat (4) @(posedge clk_sys);
        chk(32'(torque_out), 32'h1000);
    endtask

    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_win(32'h11, 1000, 20, 0, 3000, -2000);
        t_win(32'h11, -1000, 0, 0, 0, -1000);
        t_win(32'h21, 0, 0, 500, 500, 0);
        t_win(32'h11, 32767, 100, 0, 32767, -10000);
        t_win(32'h0010_C201, 0, 0, 0, 0, -200);
        t_win(32'h0010_C001, 0, 0, 0, 100, 0);
        t_win(32'h0000_C201, 0, 0, 0, 0, 0);
        t_win(32'h0010_0201, 0, 0, 0, 0, -300);
        t_speed();
        t_filt();
        stop_test();
    end
endmodule

bind tmsl_top tmsl_checker #(.W(W), .N_DI(N_DI)) u_chk (.clk_sys, .rst_b, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .dig_in, .dig_fn, .torque_ref,
    .torque_out, .torque_mode);

// ### sim/tmsl_checker.sv
// Checker for tmsl_top: bus handshake, mode select, filter direction.
// Watches top-level ports only; bound from the bench top file.
module tmsl_checker #(
    parameter int W    = 16,                    // Data width
    parameter int N_DI = 8                      // Digital inputs
) (
    // Clock and reset
    input wire logic                clk_sys,
    input wire logic                rst_b,
    // Wishbone
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [7:0]          wb_adr_i,
    input wire logic [31:0]         wb_dat_o,
    input wire logic                wb_ack_o,
    // Mode inputs and torque path
    input wire logic [N_DI-1:0]     dig_in,
    input wire logic [8*N_DI-1:0]   dig_fn,
    input wire logic signed [W-1:0] torque_ref,
    input wire logic signed [W-1:0] torque_out,
    input wire logic                torque_mode
);
    logic       take;                           // Request taken this edge
    logic       di_torq;                        // An input selects torque
    logic [2:0] still_q;                        // Cycles of steady reference

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Request qualifier
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Torque selection by digital inputs
    always_comb
    begin
        di_torq = 1'b0;
        for (int i = 0; i < N_DI; i++)
            if (dig_in[i] && dig_fn[8*i +: 8] == tmsl_pkg::DI_FN_TORQ)
                di_torq = 1'b1;
    end

    // Count cycles of a steady reference
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || !$stable(torque_ref))
            still_q <= 3'h0;
        else if (still_q != 3'h7)
            still_q <= still_q + 3'h1;
    end

    sequence s_rd_stat;
        take && !wb_we_i && wb_adr_i == tmsl_pkg::REG_STAT;
    endsequence

    a_ack_next: assert property (take |=> wb_ack_o)
        else $error("no ack after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i > tmsl_pkg::REG_TORQUE
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_stat_mode: assert property (s_rd_stat |=> wb_dat_o[2] == $past(torque_mode))
        else $error("status mode bit wrong");
    a_stat_speed: assert property (s_rd_stat ##0 !torque_mode |=> wb_dat_o[1:0] == 2'h0)
        else $error("window active in speed control");
    // Pin passes a three-stage synchroniser before it selects the mode
    a_mode_digital: assert property (di_torq [*5] |=> torque_mode)
        else $error("digital input did not select torque");
    a_filter_toward: assert property (still_q >= 3'h3 && !torque_mode && !$past(torque_mode)
        && torque_out < torque_ref |=> torque_mode
        || (torque_out >= $past(torque_out) && torque_out <= torque_ref))
        else $error("filter output moved away from reference");
endmodule

// ### sim/tmsl_motor_model.sv
// Partner model: motor speed feedback and override torque magnitude.
// Speed follows the bench set point one clock later.
module tmsl_motor_model #(
    parameter int                 W    = 16,          // Data width
    parameter logic signed [15:0] PULL = 16'h0400     // Override magnitude
) (
    input wire logic                clk_sys,
    input wire logic                rst_b,
    input wire logic signed [W-1:0] speed_set,
    input wire logic signed [W-1:0] torque_out,
    output logic signed [W-1:0]     speed_fb,
    output logic signed [W-1:0]     torque_pull
);
    // Pull magnitude stays positive
    assign torque_pull = W'(PULL);
    // Shaft speed lags the set point
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            speed_fb <= '0;
        else
            speed_fb <= speed_set;
    end
endmodule

// ### verilog/tmsl_top.sv
// Torque-mode speed limiter: filter, limit source, asymmetric window, torque override.
// Assumes analog samples, speed and torque reference are on clk_sys already;
// digital inputs come straight from pins and are synchronised here.
// Behaviour
// - Torque reference through programmable first-order filter
// - Window acts only in torque control
// - Source 0 takes limit from analog inputs
// - Source 1 takes stored limit value
// - Source 2 takes serial-link limit word
// - Second input code 12 adds to first
// - Level select 2,3 bipolar; 0,1 unipolar
// - Analog limit needs frequency source 1
// - Positive limit: upper limit+bias, lower -bias
// - Negative limit: lower -(limit+bias), upper +bias
// - Zero bias clamps opposite direction at zero
// - Bias is percent of max frequency, symmetric
// - Inside window torque follows filtered reference
// - Above window force negative torque
// - Below window force forward torque
// - Mode select 1 torque, 0 speed
// - Digital input code 44 selects torque
//
// Design decisions made here: the register addresses and register access over Wishbone.
module tmsl_top #(
    parameter int W        = 16,                    // Data width of speeds and torque
    parameter int N_DI     = 8                      // Number of digital inputs
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // Analog samples, signed, taken as speed units without scaling by max frequency
    input  wire logic signed [W-1:0] analog_input_one,
    input  wire logic signed [W-1:0] analog_input_two,
    // Digital inputs and their function codes
    input  wire logic [N_DI-1:0]   dig_in,
    input  wire logic [8*N_DI-1:0] dig_fn,
    // Speed feedback and torque path
    input  wire logic signed [W-1:0] speed_fb,
    input  wire logic signed [W-1:0] torque_ref,
    input  wire logic signed [W-1:0] torque_pull,
    output logic signed [W-1:0]    torque_out,
    output logic                   torque_mode
);
    localparam logic signed [W-1:0] SMAX = {1'b0, {(W-1){1'b1}}};
    localparam logic signed [W-1:0] SMIN = {1'b1, {(W-1){1'b0}}};

    // Software registers
    logic [31:0]           ctrl_q;                  // Control word
    logic [3:0]            filt_q;                  // Filter shift
    logic signed [W-1:0]   limit_q;                 // Stored limit
    logic [7:0]            bias_q;                  // Bias percent
    logic signed [W-1:0]   comm_q;                  // Serial-link limit
    logic [W-1:0]          maxf_q;                  // Max frequency scale
    logic                  ack_q;                   // Bus acknowledge
    logic [31:0]           rdat_q;                  // Read data

    // Datapath state
    logic signed [W+15:0]  filt_acc_q;              // Filter accumulator, 16 frac bits
    logic signed [W-1:0]   upper_q;                 // Upper boundary
    logic signed [W-1:0]   lower_q;                 // Lower boundary
    logic signed [W-1:0]   torque_q;                // Torque output
    logic [1:0]            win_q;                   // Window state
    logic                  mode_q;                  // Torque mode flag

    // Combinational helpers
    logic [N_DI-1:0]       di_torq;                 // Inputs asking for torque mode
    logic                  mode_d;                  // Next mode
    logic signed [W-1:0]   ain1;                    // First input after level select
    logic signed [W-1:0]   ain_lim;                 // Analog limit value
    logic signed [W-1:0]   lim_d;                   // Selected limit
    logic signed [W-1:0]   bias_v;                  // Bias in speed units
    logic signed [W-1:0]   upper_d;                 // Next upper boundary
    logic signed [W-1:0]   lower_d;                 // Next lower boundary
    logic signed [W-1:0]   filt_y;                  // Filter output
    logic [1:0]            src;                     // Limit source
    logic [3:0]            lvl1;                    // Level select of first input
    logic [W+7:0]          bias_prod;               // Bias times max frequency
    logic                  req;                     // Bus request this cycle
    logic signed [W+31:0]  filt_diff;               // Reference minus accumulator
    logic signed [W+31:0]  filt_step;               // Difference after the shift

    // Field extracts from the control word
    assign src  = ctrl_q[tmsl_pkg::CTRL_SRC_LSB +: 2];
    assign lvl1 = ctrl_q[tmsl_pkg::CTRL_AIN1_LSB +: 4];
    assign req  = wb_cyc_i & wb_stb_i & ~ack_q;

    // Saturating add of two signed values
    function automatic logic signed [W-1:0] sat_add(input logic signed [W-1:0] a,
                                                    input logic signed [W-1:0] b);
        // One extra bit catches the overflow
        logic signed [W:0] s;
        s = {a[W-1], a} + {b[W-1], b};
        if (s[W] != s[W-1])
            sat_add = s[W] ? SMIN : SMAX;
        else
            sat_add = s[W-1:0];
    endfunction

    // Saturating negate
    function automatic logic signed [W-1:0] sat_neg(input logic signed [W-1:0] a);
        sat_neg = (a == SMIN) ? SMAX : -a;
    endfunction

    // Digital inputs: three-stage synchroniser, then the mode switch function
    genvar gi;
    generate
        for (gi = 0; gi < N_DI; gi++)
        begin : g_di
            logic sync1_q;                          // First stage, may go metastable
            logic sync2_q;                          // Second stage
            logic sync3_q;                          // Third stage
            logic level_q;                          // Accepted input level
            // Shift the pin through the chain; accept a level both late stages agree on
            always_ff @(posedge clk_sys)
            begin
                if (!rst_b)
                begin
                    sync1_q <= 1'b0;
                    sync2_q <= 1'b0;
                    sync3_q <= 1'b0;
                    level_q <= 1'b0;                // Idle level of an inactive input
                end
                else
                begin
                    sync1_q <= dig_in[gi];
                    sync2_q <= sync1_q;
                    sync3_q <= sync2_q;
                    if (sync2_q == sync3_q)
                        level_q <= sync3_q;         // Change counts once stable
                end
            end
            // Input asks for torque control when active and coded for it
            assign di_torq[gi] = level_q & (dig_fn[8*gi +: 8] == tmsl_pkg::DI_FN_TORQ);
        end
    endgenerate

    // Mode choice: register select, or asserted digital input
    assign mode_d = ctrl_q[tmsl_pkg::CTRL_MODE_BIT] | (|di_torq);

    // Analog limit formation
    always_comb
    begin
        // Unipolar levels clamp negative samples to zero
        if (lvl1 == 4'h2 || lvl1 == 4'h3)
            ain1 = analog_input_one;
        else
            ain1 = analog_input_one[W-1] ? '0 : analog_input_one;
        // Second input sums in when so assigned
        if (ctrl_q[tmsl_pkg::CTRL_FN2_LSB +: 8] == tmsl_pkg::FN2_ADD)
            ain_lim = sat_add(ain1, analog_input_two);
        else
            ain_lim = ain1;
    end

    // Limit source select
    always_comb
    begin
        unique case (src)
            tmsl_pkg::SRC_ANALOG:
                // Analog limit only with analog frequency source
                lim_d = (ctrl_q[tmsl_pkg::CTRL_FSRC_LSB +: 4] == tmsl_pkg::FSRC_ANALOG)
                        ? ain_lim : '0;
            tmsl_pkg::SRC_STORED:
                lim_d = limit_q;
            tmsl_pkg::SRC_COMM:
                lim_d = comm_q;
            default:
                lim_d = '0;                                          // Illegal code
        endcase
    end

    // Bias scaled from percent of max frequency
    assign bias_prod = maxf_q * bias_q;
    always_comb
    begin
        // Divide by 100, clamp to positive range
        if ((bias_prod / 100) > {8'h00, SMAX})
            bias_v = SMAX;
        else
            bias_v = W'(bias_prod / 100);
    end

    // Window boundaries from polarity of the limit
    always_comb
    begin
        if (!lim_d[W-1])
        begin
            // Positive or zero limit opens the window forward
            upper_d = sat_add(lim_d, bias_v);
            lower_d = sat_neg(bias_v);
        end
        else
        begin
            // Negative limit opens it in reverse
            upper_d = bias_v;
            lower_d = sat_add(lim_d, sat_neg(bias_v));
        end
    end

    assign filt_y = filt_acc_q[W+15:16];

    // Wishbone slave: one-cycle ack, writes with byte lanes
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            ctrl_q  <= tmsl_pkg::CTRL_RST;
            filt_q  <= tmsl_pkg::FILT_RST;
            limit_q <= '0;
            bias_q  <= '0;
            comm_q  <= '0;
            maxf_q  <= W'(tmsl_pkg::MAXF_RST);
        end
        else if (req && wb_we_i)
        begin
            unique case (wb_adr_i)
                // Control word, every byte lane on its own
                tmsl_pkg::REG_CTRL:
                    for (int b = 0; b < 4; b++)
                        if (wb_sel_i[b]) ctrl_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
                // Filter shift, low lane only
                tmsl_pkg::REG_FILT:
                    if (wb_sel_i[0]) filt_q <= wb_dat_i[3:0];
                // Stored limit needs both low lanes
                tmsl_pkg::REG_LIMIT:
                    if (&wb_sel_i[1:0]) limit_q <= wb_dat_i[W-1:0];
                // Bias percent, low lane only
                tmsl_pkg::REG_BIAS:
                    if (wb_sel_i[0]) bias_q <= wb_dat_i[7:0];
                // Limit word from the serial link
                tmsl_pkg::REG_COMM:
                    if (&wb_sel_i[1:0]) comm_q <= wb_dat_i[W-1:0];
                // Scale of the bias percentage
                tmsl_pkg::REG_MAXF:
                    if (&wb_sel_i[1:0]) maxf_q <= wb_dat_i[W-1:0];
                default:
                    ;                                                // Unmapped: ignored
            endcase
        end
    end

    // Ack and read data
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            ack_q  <= 1'b0;
            rdat_q <= '0;
        end
        else
        begin
            ack_q <= req;
            // Read mux samples the addressed register every cycle
            unique case (wb_adr_i)
                tmsl_pkg::REG_CTRL:   rdat_q <= ctrl_q;
                tmsl_pkg::REG_FILT:   rdat_q <= {28'h0, filt_q};
                tmsl_pkg::REG_LIMIT:  rdat_q <= 32'(limit_q);
                tmsl_pkg::REG_BIAS:   rdat_q <= {24'h0, bias_q};
                tmsl_pkg::REG_COMM:   rdat_q <= 32'(comm_q);
                tmsl_pkg::REG_MAXF:   rdat_q <= 32'(maxf_q);
                tmsl_pkg::REG_STAT:   rdat_q <= {29'h0, mode_q, win_q};
                tmsl_pkg::REG_UPPER:  rdat_q <= 32'(upper_q);
                tmsl_pkg::REG_LOWER:  rdat_q <= 32'(lower_q);
                tmsl_pkg::REG_TORQUE: rdat_q <= 32'(torque_q);
                default:              rdat_q <= 32'h0000_0000;       // Unmapped reads zero
            endcase
        end
    end

    // Filter error; both sides signed so the shift keeps the sign
    assign filt_diff = $signed({{16{torque_ref[W-1]}}, torque_ref, 16'h0000})
                     - $signed({{16{filt_acc_q[W+15]}}, filt_acc_q});
    // Larger shift gives a longer time constant
    assign filt_step = filt_diff >>> filt_q;

    // First-order low-pass: acc += (x - y) >> shift
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            filt_acc_q <= '0;                                        // Output starts at zero
        else
            // Only the accumulator's width of the step is kept
            filt_acc_q <= filt_acc_q + filt_step[W+15:0];
    end

    // Window registers and mode
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            upper_q <= '0;
            lower_q <= '0;
            mode_q  <= 1'b0;
        end
        else
        begin
            // Bounds follow the limit one cycle later
            upper_q <= upper_d;
            lower_q <= lower_d;
            mode_q  <= mode_d;
        end
    end

    // Window compare and torque override
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            torque_q <= '0;
            win_q    <= tmsl_pkg::WIN_INSIDE;
        end
        else if (!mode_q)
        begin
            // Speed control: no window on this path
            torque_q <= filt_y;
            win_q    <= tmsl_pkg::WIN_INSIDE;
        end
        else if (speed_fb > upper_q)
        begin
            // Above the upper boundary: brake with negative torque
            torque_q <= sat_neg(torque_pull);
            win_q    <= tmsl_pkg::WIN_ABOVE;
        end
        else if (speed_fb < lower_q)
        begin
            // Below the lower boundary: push forward
            torque_q <= torque_pull;
            win_q    <= tmsl_pkg::WIN_BELOW;
        end
        else
        begin
            // Inside the window: follow the filtered reference
            torque_q <= filt_y;
            win_q    <= tmsl_pkg::WIN_INSIDE;
        end
    end

    assign torque_out  = torque_q;
    assign torque_mode = mode_q;
    assign wb_dat_o    = rdat_q;
    assign wb_ack_o    = ack_q;
endmodule
